// >>> rtccal_pkg.sv
// package of constants and types for the clock/calendar core
// Notes on behaviour
// - one second update period advances calendar
// - freeze holds visible bytes; internal copy counts
// - pending bit leads update; then done flag
// - bytes binary or BCD by format bit
// - twelve hour mode puts PM in bit 7
// - weekday 1-7, day 1-31, month, year 0-99
// - after unfreeze next update takes written bytes
// - divide time base; taps feed a selector
// - rate field picks tap, zero gives none
// - wave pin driven only when output enabled
// - code 011 with enables outputs fast clock
// - code 011 leaves periodic timing unchanged
// - periodic enable requests once per period
// - events set flags; enabled ones request interrupt
// - flag register read clears flags, releases pin
// - update compares time with alarm bytes
// - alarm byte with top bits set ignored
// - alarm logic stays live on backup power
// - update request needs enable and no freeze
// - interrupt pin low while enabled flag set
// - wave pin low when output disabled
// - oscillator codes 010 and 011 run divider, all others hold it at start
package rtccal_pkg;
	// ***************************************
	// register map
	// ***************************************
	localparam logic [6:0] RTCCAL_SEC = 7'h00;
	localparam logic [6:0] RTCCAL_SEC_ALM = 7'h01;
	localparam logic [6:0] RTCCAL_MIN = 7'h02;
	localparam logic [6:0] RTCCAL_MIN_ALM = 7'h03;
	localparam logic [6:0] RTCCAL_HR = 7'h04;
	localparam logic [6:0] RTCCAL_HR_ALM = 7'h05;
	localparam logic [6:0] RTCCAL_WDAY = 7'h06;
	localparam logic [6:0] RTCCAL_MDAY = 7'h07;
	localparam logic [6:0] RTCCAL_MON = 7'h08;
	localparam logic [6:0] RTCCAL_YEAR = 7'h09;
	localparam logic [6:0] RTCCAL_CTRL_A = 7'h0A;
	localparam logic [6:0] RTCCAL_CTRL_B = 7'h0B;
	localparam logic [6:0] RTCCAL_FLAGS = 7'h0C;
	localparam logic [6:0] RTCCAL_CTRL_D = 7'h0D;
	localparam int RTCCAL_NBYTES = 10;
	// ***************************************
	// field positions
	// ***************************************
	localparam int B_FREEZE = 7;
	localparam int B_PIE = 6;
	localparam int B_AIE = 5;
	localparam int B_UIE = 4;
	localparam int B_WAVE = 3;
	localparam int B_FMT = 2;
	localparam int B_HR12 = 1;
	localparam int C_REQUEST_PENDING_FLAG = 7;
	localparam int C_PF = 6;
	localparam int C_AF = 5;
	localparam int C_UF = 4;
	localparam int C_FAST = 0;
	localparam logic [2:0] OSC_RUN = 3'b010;
	localparam logic [2:0] OSC_FAST = 3'b011;
	localparam logic [1:0] OSC_HOLD = 2'b11;
	localparam logic [7:0] DONT_CARE = 8'hC0;
	localparam logic [7:0] CTRL_A_RST = 8'h00;
	localparam logic [7:0] CTRL_B_RST = 8'h00;
	// ***************************************
	// timing
	// ***************************************
	localparam int CLK_HZ = 40000000;
	localparam int TBASE_HZ = 32768;
	localparam int DIV_W = 15;
	// pending lead and first update delay, in time base ticks
	localparam int LEAD_US = 244;
	localparam int LEAD_TICKS = (LEAD_US * TBASE_HZ + 999999) / 1000000;
	localparam int FIRST_MS = 500;
	localparam int FIRST_TICKS = FIRST_MS * TBASE_HZ / 1000;
	typedef struct packed {
		logic [7:0] year;
		logic [7:0] mon;
		logic [7:0] mday;
		logic [7:0] wday;
		logic [7:0] hr;
		logic [7:0] min;
		logic [7:0] sec;
	} rtccal_time_type;
endpackage

// >>> rtccal_core.sv
// clock/calendar core with alarm, wave output and events
`timescale 1ns/100ps
module rtccal_core import rtccal_pkg::*; (
	// clock and reset
	input wire logic CLK_SYS_IN,
	input wire logic RST_N_IN,
	// time base tick, 32.768 kHz enable from oscillator
	input wire logic TBASE_IN,
	// multiplexed bus
	input wire logic [7:0] AD_IN,
	output logic [7:0] AD_OUT,
	output logic AD_OE_OUT,
	input wire logic AS_IN,
	input wire logic DS_N_IN,
	input wire logic WR_N_IN,
	input wire logic CS_N_IN,
	// pins
	output logic IRQ_N_OUT,
	output logic IRQ_OE_OUT,
	output logic WAVE_OUT
);
	// ***************************************
	// pin synchronisers
	// ***************************************
	logic [5:0] s1_q, s2_q, s3_q;
	logic [7:0] ad1_q, ad2_q;
	always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			// idle pin levels, so no false strobe edge follows reset
			s1_q <= 6'h3C;
			s2_q <= 6'h3C;
			s3_q <= 6'h3C;
			ad1_q <= 8'h00;
			ad2_q <= 8'h00;
		end else begin
			s1_q <= {CS_N_IN, WR_N_IN, DS_N_IN, 1'b1, AS_IN, TBASE_IN};
			s2_q <= s1_q;
			s3_q <= s2_q;
			ad1_q <= AD_IN;
			ad2_q <= ad1_q;
		end
	end
	logic tick, as_fall, rd_fall, wr_rise, rd_act, cs_act;
	assign tick = s2_q[0] & ~s3_q[0];
	assign as_fall = ~s2_q[1] & s3_q[1];
	assign rd_act = ~s2_q[3];
	assign rd_fall = ~s2_q[3] & s3_q[3];
	assign wr_rise = s2_q[4] & ~s3_q[4];
	assign cs_act = ~s2_q[5];

	// ***************************************
	// bcd and binary helpers
	// ***************************************
	function automatic logic [7:0] inc8(input logic [7:0] v,
			input logic bcd);
		if (bcd && v[3:0] == 4'h9)
			inc8 = {v[7:4] + 4'h1, 4'h0};
		else
			inc8 = v + 8'h01;
	endfunction
	function automatic logic [7:0] mlen(input logic [7:0] m,
			input logic [7:0] y, input logic bcd);
		logic [7:0] mb, yb;
		mb = bcd ? 8'(m[7:4] * 4'hA + m[3:0]) : m;
		yb = bcd ? 8'(y[7:4] * 4'hA + y[3:0]) : y;
		unique case (mb)
			8'h02: mlen = (yb[1:0] == 2'b00) ? 8'h1D : 8'h1C;
			8'h04, 8'h06, 8'h09, 8'h0B: mlen = 8'h1E;
			default: mlen = 8'h1F;
		endcase
		if (bcd)
			mlen = (mlen == 8'h1F) ? 8'h31 : (mlen == 8'h1E) ? 8'h30 :
				{4'h2, mlen[3:0] - 4'h4};
	endfunction

	// ***************************************
	// control registers
	// ***************************************
	logic [7:0] ctrl_a_q, ctrl_b_q;
	logic fast_en_q;
	logic [6:0] addr_q;
	logic wr_ev;
	rtccal_time_type live_q, vis_q;
	logic [7:0] alm_s_q, alm_m_q, alm_h_q;
	logic pend_q, freeze_q;
	logic [2:0] flags_q;
	logic flag_rd;
	assign wr_ev = wr_rise & cs_act;
	assign flag_rd = rd_fall & cs_act & (addr_q == RTCCAL_FLAGS);
	always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
		if (!RST_N_IN)
			addr_q <= 7'h00;
		else if (as_fall)
			addr_q <= ad2_q[6:0];
	end
	always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			ctrl_a_q <= CTRL_A_RST;
			ctrl_b_q <= CTRL_B_RST;
			fast_en_q <= 1'b0;
		end else if (wr_ev) begin
			if (addr_q == RTCCAL_CTRL_A)
				ctrl_a_q <= {1'b0, ad2_q[6:0]};
			if (addr_q == RTCCAL_CTRL_B)
				ctrl_b_q <= ad2_q;
			if (addr_q == RTCCAL_FLAGS && ctrl_a_q[6:4] == OSC_FAST)
				fast_en_q <= ad2_q[C_FAST];
		end
	end
	logic fmt_bin;
	assign fmt_bin = ctrl_b_q[B_FMT];
	assign freeze_q = ctrl_b_q[B_FREEZE];

	// ***************************************
	// divider and rate selector
	// ***************************************
	// held divider waits short of its wrap, so the first update
	// follows the start delay rather than a full second
	localparam logic [DIV_W-1:0] DIV_START =
		DIV_W'((1 << DIV_W) - FIRST_TICKS);
	logic [DIV_W-1:0] div_q;
	logic div_run;
	assign div_run = ctrl_a_q[6:4] == OSC_RUN || ctrl_a_q[6:4] == OSC_FAST;
	always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
		if (!RST_N_IN)
			div_q <= DIV_START;
		else if (!div_run)
			div_q <= DIV_START;
		else if (tick)
			div_q <= div_q + 1'b1;
	end
	logic [3:0] rs;
	logic [3:0] tap;
	logic rate_on, rate_lvl;
	assign rs = ctrl_a_q[3:0];
	// codes 1 and 2 reuse the 256 and 128 Hz taps
	assign tap = (rs == 4'h1) ? 4'h6 : (rs == 4'h2) ? 4'h7 : rs - 4'h2;
	assign rate_on = rs != 4'h0 && div_run;
	assign rate_lvl = rate_on & div_q[tap];
	logic rate_prev_q, per_ev;
	always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
		if (!RST_N_IN)
			rate_prev_q <= 1'b0;
		else
			rate_prev_q <= rate_lvl;
	end
	assign per_ev = rate_prev_q & ~rate_lvl & rate_on;
	always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
		if (!RST_N_IN)
			WAVE_OUT <= 1'b0;
		else if (!ctrl_b_q[B_WAVE])
			WAVE_OUT <= 1'b0;
		else if (ctrl_a_q[6:4] == OSC_FAST && fast_en_q)
			WAVE_OUT <= s2_q[0];
		else
			WAVE_OUT <= rate_lvl;
	end

	// ***************************************
	// update cycle sequencing
	// ***************************************
	logic sec_edge, lead_edge, upd_ev;
	assign sec_edge = tick && div_run && div_q == '1;
	assign lead_edge = tick && div_run &&
		div_q == DIV_W'((1 << DIV_W) - LEAD_TICKS);
	assign upd_ev = sec_edge;
	always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
		if (!RST_N_IN)
			pend_q <= 1'b0;
		else if (freeze_q || upd_ev)
			pend_q <= 1'b0;
		else if (lead_edge)
			pend_q <= 1'b1;
	end

	// ***************************************
	// calendar counting
	// ***************************************
	logic take_q;
	rtccal_time_type nx;
	logic [7:0] h_lo, h_hi, hr_n, hr_inc;
	always_comb begin
		nx = live_q;
		h_lo = ctrl_b_q[B_HR12] ? 8'h01 : 8'h00;
		h_hi = ctrl_b_q[B_HR12] ? (fmt_bin ? 8'h0C : 8'h12) :
			(fmt_bin ? 8'h17 : 8'h23);
		hr_n = {1'b0, live_q.hr[6:0]};
		hr_inc = inc8(hr_n, !fmt_bin);
		nx.sec = inc8(live_q.sec, !fmt_bin);
		if (live_q.sec == (fmt_bin ? 8'h3B : 8'h59)) begin
			nx.sec = 8'h00;
			nx.min = inc8(live_q.min, !fmt_bin);
			if (live_q.min == (fmt_bin ? 8'h3B : 8'h59)) begin
				nx.min = 8'h00;
				nx.hr = {live_q.hr[7], hr_inc[6:0]};
				if (ctrl_b_q[B_HR12] && hr_n == h_hi - 8'h01)
					nx.hr[7] = ~live_q.hr[7];
				if (hr_n == h_hi) begin
					nx.hr = {ctrl_b_q[B_HR12] & live_q.hr[7], h_lo[6:0]};
					if (!ctrl_b_q[B_HR12] || live_q.hr[7] == 1'b0) begin
						nx.hr[7] = 1'b0;
					end
				end
				if (!ctrl_b_q[B_HR12] && hr_n == h_hi ||
						ctrl_b_q[B_HR12] && live_q.hr[7] &&
						hr_n == h_hi - 8'h01) begin
					nx.hr = ctrl_b_q[B_HR12] ? (fmt_bin ? 8'h0C : 8'h12)
						: 8'h00;
					nx.wday = (live_q.wday == 8'h07) ? 8'h01 :
						live_q.wday + 8'h01;
					nx.mday = inc8(live_q.mday, !fmt_bin);
					if (live_q.mday == mlen(live_q.mon, live_q.year,
							!fmt_bin)) begin
						nx.mday = 8'h01;
						nx.mon = inc8(live_q.mon, !fmt_bin);
						if (live_q.mon == (fmt_bin ? 8'h0C : 8'h12)) begin
							nx.mon = 8'h01;
							nx.year = (live_q.year == (fmt_bin ? 8'h63 :
								8'h99)) ? 8'h00 : inc8(live_q.year, !fmt_bin);
						end
					end
				end
			end
		end
	end
	// host bytes written while frozen are taken at the first update after unfreeze
	always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
		if (!RST_N_IN)
			take_q <= 1'b0;
		else if (upd_ev && !freeze_q)
			take_q <= 1'b0;
		else if (wr_ev && addr_q < 7'(RTCCAL_NBYTES))
			take_q <= 1'b1;
	end
	always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
		if (!RST_N_IN)
			live_q <= '0;
		else if (upd_ev) begin
			if (take_q && !freeze_q)
				live_q <= vis_q;
			else
				live_q <= nx;
		end
	end
	logic [7:0] wd;
	assign wd = ad2_q;
	always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
		if (!RST_N_IN)
			vis_q <= '0;
		else if (upd_ev && !freeze_q)
			vis_q <= (take_q) ? vis_q : nx;
		else if (wr_ev) begin
			unique case (addr_q)
				RTCCAL_SEC: vis_q.sec <= wd;
				RTCCAL_MIN: vis_q.min <= wd;
				RTCCAL_HR: vis_q.hr <= wd;
				RTCCAL_WDAY: vis_q.wday <= wd;
				RTCCAL_MDAY: vis_q.mday <= wd;
				RTCCAL_MON: vis_q.mon <= wd;
				RTCCAL_YEAR: vis_q.year <= wd;
				default: ;
			endcase
		end
	end
	always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			alm_s_q <= 8'h00;
			alm_m_q <= 8'h00;
			alm_h_q <= 8'h00;
		end else if (wr_ev) begin
			if (addr_q == RTCCAL_SEC_ALM)
				alm_s_q <= wd;
			if (addr_q == RTCCAL_MIN_ALM)
				alm_m_q <= wd;
			if (addr_q == RTCCAL_HR_ALM)
				alm_h_q <= wd;
		end
	end

	// ***************************************
	// alarm and event flags
	// ***************************************
	function automatic logic amatch(input logic [7:0] a, input logic [7:0] v);
		amatch = (a[7:6] == DONT_CARE[7:6]) || a == v;
	endfunction
	logic alm_ev, upd_done;
	rtccal_time_type nt;
	// compare with the time this update loads, host bytes included
	assign nt = (take_q && !freeze_q) ? vis_q : nx;
	// no supply gating here, so alarm runs in any power state
	assign alm_ev = upd_ev && amatch(alm_s_q, nt.sec) &&
		amatch(alm_m_q, nt.min) && amatch(alm_h_q, nt.hr);
	assign upd_done = upd_ev;
	logic [2:0] ev, en;
	assign ev = {per_ev, alm_ev, upd_done};
	assign en = {ctrl_b_q[B_PIE], ctrl_b_q[B_AIE],
		ctrl_b_q[B_UIE] & ~freeze_q};
	logic [2:0] flags_d;
	logic req_q, req_d;
	// set wins over the read clear, so no event is lost
	assign flags_d = (flag_rd ? 3'b000 : flags_q) | ev;
	// level request: enabling an already set flag also pulls the pin
	assign req_d = |(flags_d & en);
	always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
		if (!RST_N_IN)
			flags_q <= 3'b000;
		else
			flags_q <= flags_d;
	end
	always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
		if (!RST_N_IN)
			req_q <= 1'b0;
		else
			req_q <= req_d;
	end
	always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			IRQ_N_OUT <= 1'b1;
			IRQ_OE_OUT <= 1'b0;
		end else begin
			IRQ_N_OUT <= 1'b0;
			IRQ_OE_OUT <= req_d;
		end
	end

	// ***************************************
	// read path
	// ***************************************
	logic [7:0] rd_mux;
	always_comb begin
		unique case (addr_q)
			RTCCAL_SEC: rd_mux = vis_q.sec;
			RTCCAL_SEC_ALM: rd_mux = alm_s_q;
			RTCCAL_MIN: rd_mux = vis_q.min;
			RTCCAL_MIN_ALM: rd_mux = alm_m_q;
			RTCCAL_HR: rd_mux = vis_q.hr;
			RTCCAL_HR_ALM: rd_mux = alm_h_q;
			RTCCAL_WDAY: rd_mux = vis_q.wday;
			RTCCAL_MDAY: rd_mux = vis_q.mday;
			RTCCAL_MON: rd_mux = vis_q.mon;
			RTCCAL_YEAR: rd_mux = vis_q.year;
			RTCCAL_CTRL_A: rd_mux = {pend_q, ctrl_a_q[6:0]};
			RTCCAL_CTRL_B: rd_mux = ctrl_b_q;
			RTCCAL_FLAGS: rd_mux = {req_q, flags_q, 3'b000, fast_en_q};
			default: rd_mux = 8'h00;
		endcase
	end
	always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			AD_OUT <= 8'h00;
			AD_OE_OUT <= 1'b0;
		end else begin
			// held from the strobe, so a flag read shows what it clears
			if (rd_fall)
				AD_OUT <= rd_mux;
			AD_OE_OUT <= rd_act & cs_act;
		end
	end

	// ***************************************
	// checks
	// ***************************************
	chk_pend_clear: assert property (@(posedge CLK_SYS_IN)
		disable iff (!RST_N_IN) upd_ev |=> !pend_q)
		else $error("pending bit not cleared after update");
	chk_done_flag: assert property (@(posedge CLK_SYS_IN)
		disable iff (!RST_N_IN) upd_ev |=> flags_q[0])
		else $error("update done flag not set");
	chk_read_clear: assert property (@(posedge CLK_SYS_IN)
		disable iff (!RST_N_IN) flag_rd && ev == 3'b000 |=> !req_q &&
		flags_q == 3'b000)
		else $error("flag read did not clear");
	chk_wave_low: assert property (@(posedge CLK_SYS_IN)
		disable iff (!RST_N_IN) !ctrl_b_q[B_WAVE] |=> !WAVE_OUT)
		else $error("wave pin not low when disabled");
	chk_irq_drive: assert property (@(posedge CLK_SYS_IN)
		disable iff (!RST_N_IN) |(ev & en) |=> IRQ_OE_OUT)
		else $error("interrupt not driven");
	chk_freeze_hold: assert property (@(posedge CLK_SYS_IN)
		disable iff (!RST_N_IN) freeze_q && !wr_ev |=> $stable(vis_q))
		else $error("visible bytes changed while frozen");
	chk_alarm_flag: assert property (@(posedge CLK_SYS_IN)
		disable iff (!RST_N_IN) alm_ev |=> flags_q[1])
		else $error("alarm flag not set");
	chk_div_hold: assert property (@(posedge CLK_SYS_IN)
		disable iff (!RST_N_IN) !div_run |=> div_q == DIV_START && !upd_ev)
		else $error("divider ran while held");
	cov_update: cover property (@(posedge CLK_SYS_IN) upd_ev);
	cov_alarm: cover property (@(posedge CLK_SYS_IN) alm_ev && en[1]);
	cov_periodic: cover property (@(posedge CLK_SYS_IN) per_ev && en[2]);
endmodule

// >>> rtccal_host.sv
// host processor model on the multiplexed address/data bus
`timescale 1ns/100ps
module rtccal_host import rtccal_pkg::*; (
	// clock
	input wire logic CLK_SYS_IN,
	// device side of the bus
	input wire logic [7:0] DEV_AD_IN,
	input wire logic DEV_OE_IN,
	output logic [7:0] BUS_OUT,
	output logic AS_OUT,
	output logic DS_N_OUT,
	output logic WR_N_OUT,
	output logic CS_N_OUT,
	// checked read results
	output logic RD_DONE_OUT,
	output logic [7:0] RD_DATA_OUT
);
	logic drv;
	logic [7:0] dat;
	logic [7:0] last_q = 8'h00;
	// ***************************************
	// bus wire
	// ***************************************
	// released bus shows a changing pattern, never a stale value
	assign BUS_OUT = DEV_OE_IN ? DEV_AD_IN : (drv ? dat : ~last_q);
	always @(posedge CLK_SYS_IN) begin
		last_q <= BUS_OUT;
	end
	initial begin
		drv = 1'b0;
		dat = 8'h00;
		AS_OUT = 1'b0;
		DS_N_OUT = 1'b1;
		WR_N_OUT = 1'b1;
		CS_N_OUT = 1'b1;
		RD_DONE_OUT = 1'b0;
		RD_DATA_OUT = 8'h00;
	end
	// ***************************************
	// bus cycles
	// ***************************************
	task automatic cyc(input int n);
		repeat (n) @(posedge CLK_SYS_IN);
		#2;
	endtask
	task automatic addr(input logic [7:0] a);
		dat = a;
		drv = 1'b1;
		AS_OUT = 1'b1;
		cyc(2);
		AS_OUT = 1'b0;
		cyc(4);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		addr(a);
		dat = d;
		CS_N_OUT = 1'b0;
		cyc(4);
		WR_N_OUT = 1'b0;
		cyc(4);
		WR_N_OUT = 1'b1;
		cyc(4);
		CS_N_OUT = 1'b1;
		drv = 1'b0;
		cyc(4);
	endtask
	task automatic rd(input logic [7:0] a, input bit chk,
			output logic [7:0] d);
		addr(a);
		drv = 1'b0;
		CS_N_OUT = 1'b0;
		DS_N_OUT = 1'b0;
		cyc(6);
		d = DEV_AD_IN;
		RD_DATA_OUT = d;
		RD_DONE_OUT = chk;
		DS_N_OUT = 1'b1;
		CS_N_OUT = 1'b1;
		cyc(1);
		RD_DONE_OUT = 1'b0;
		cyc(4);
	endtask
endmodule

// >>> rtccal_core_tb.sv
// self-checking testbench of the clock/calendar core
`timescale 1ns/100ps
module rtccal_core_tb import rtccal_pkg::*;;
	logic clk, rst_n, tbase, as_s, ds_n, wr_n, cs_n;
	logic [7:0] ad_in, ad_out, rd_data, v, a8;
	logic ad_oe, irq_n, irq_oe, wave, rd_done, hi, lo;
	int errors = 0;
	int checked = 0;
	int cycles = 0;
	int seed = 63781;
	logic [7:0] expq[$];
	logic [7:0] tset[10] = '{8'h3B, 8'hC0, 8'h3B, 8'hC0, 8'h17, 8'hC0,
		8'h07, 8'h1F, 8'h0C, 8'h63};
	rtccal_core DUT (.CLK_SYS_IN(clk), .RST_N_IN(rst_n), .TBASE_IN(tbase),
		.AD_IN(ad_in), .AD_OUT(ad_out), .AD_OE_OUT(ad_oe), .AS_IN(as_s),
		.DS_N_IN(ds_n), .WR_N_IN(wr_n), .CS_N_IN(cs_n), .IRQ_N_OUT(irq_n),
		.IRQ_OE_OUT(irq_oe), .WAVE_OUT(wave));
	rtccal_host host (.CLK_SYS_IN(clk), .DEV_AD_IN(ad_out),
		.DEV_OE_IN(ad_oe), .BUS_OUT(ad_in), .AS_OUT(as_s), .DS_N_OUT(ds_n),
		.WR_N_OUT(wr_n), .CS_N_OUT(cs_n), .RD_DONE_OUT(rd_done),
		.RD_DATA_OUT(rd_data));
	// ***************************************
	// clocks, time base scaled to 4 cycles a tick
	// ***************************************
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		tbase = 1'b0;
		#3;
		forever #50 tbase = ~tbase;
	end
	// ***************************************
	// checking
	// ***************************************
	task automatic cmp(input string n, input logic [7:0] e,
			input logic [7:0] g);
		checked++;
		if (g !== e) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		expq.push_back(e);
		host.rd(a, 1'b1, d);
	endtask
	always @(posedge clk) begin
		if (rd_done === 1'b1 && expq.size() > 0) begin
			cmp("read", expq.pop_front(), rd_data);
		end
	end
	task automatic wave_seen(input int n);
		hi = 1'b0;
		lo = 1'b0;
		repeat (n) begin
			@(posedge clk);
			#1;
			if (wave === 1'b1) hi = 1'b1;
			if (wave === 1'b0) lo = 1'b1;
		end
	endtask
	task automatic wait_irq(input int n);
		int k;
		for (k = 0; k < n && irq_oe !== 1'b1; k++) @(posedge clk);
		#1;
	endtask
	task automatic results();
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// long enough for the 500 ms start plus the test traffic
	always @(posedge clk) begin
		cycles++;
		if (cycles == 100000) begin
			errors++;
			results();
		end
	end
	// ***************************************
	// main sequence
	// ***************************************
	initial begin
		rst_n = 1'b0;
		repeat (4) @(posedge clk);
		#2;
		rst_n = 1'b1;
		host.cyc(4);
		cmp("irq_oe", 8'h00, {7'h00, irq_oe});
		cmp("wave", 8'h00, {7'h00, wave});
		rdchk(RTCCAL_CTRL_A, CTRL_A_RST);
		rdchk(RTCCAL_CTRL_B, CTRL_B_RST);
		rdchk(RTCCAL_CTRL_D, 8'h00);
		// fast clock bit is refused while the oscillator field is not 011
		host.wr(RTCCAL_FLAGS, 8'h01);
		rdchk(RTCCAL_FLAGS, 8'h00);
		// freeze, binary, 24 hour, then write all bytes
		host.wr(RTCCAL_CTRL_B, 8'h84);
		rdchk(RTCCAL_CTRL_B, 8'h84);
		a8 = 8'(($random(seed) & 32'h7FFFFFFF) % 60);
		host.wr(RTCCAL_SEC_ALM, a8);
		rdchk(RTCCAL_SEC_ALM, a8);
		for (int i = 0; i < RTCCAL_NBYTES; i++) host.wr(8'(i), tset[i]);
		host.wr(RTCCAL_CTRL_B, 8'h34);
		host.wr(RTCCAL_CTRL_A, 8'hA3);
		rdchk(RTCCAL_CTRL_A, 8'h23);
		wave_seen(64);
		cmp("wave_hi", 8'h00, {7'h00, hi});
		host.wr(RTCCAL_CTRL_B, 8'h3C);
		wave_seen(64);
		cmp("wave_hi", 8'h01, {7'h00, hi});
		cmp("wave_lo", 8'h01, {7'h00, lo});
		cmp("irq_oe", 8'h00, {7'h00, irq_oe});
		rdchk(RTCCAL_FLAGS, 8'h40);
		host.wr(RTCCAL_CTRL_B, 8'h74);
		wait_irq(64);
		cmp("irq_oe", 8'h01, {7'h00, irq_oe});
		cmp("irq_n", 8'h00, {7'h00, irq_n});
		host.wr(RTCCAL_CTRL_A, 8'h20);
		rdchk(RTCCAL_FLAGS, 8'hC0);
		rdchk(RTCCAL_FLAGS, 8'h00);
		cmp("irq_oe", 8'h00, {7'h00, irq_oe});
		// poll the pending bit until the first update draws near
		v = 8'h00;
		for (int k = 0; k < 6000 && v[7] !== 1'b1; k++) begin
			host.rd(RTCCAL_CTRL_A, 1'b0, v);
		end
		cmp("pending", 8'h01, {7'h00, v[7]});
		wait_irq(400);
		cmp("irq_oe", 8'h01, {7'h00, irq_oe});
		rdchk(RTCCAL_FLAGS, 8'hB0);
		rdchk(RTCCAL_CTRL_A, 8'h20);
		for (int i = 0; i < RTCCAL_NBYTES; i++) rdchk(8'(i), tset[i]);
		// undivided time base on the wave pin
		host.wr(RTCCAL_CTRL_A, 8'h30);
		host.wr(RTCCAL_FLAGS, 8'h01);
		host.wr(RTCCAL_CTRL_B, 8'h08);
		wave_seen(40);
		cmp("fast_hi", 8'h01, {7'h00, hi});
		cmp("fast_lo", 8'h01, {7'h00, lo});
		rdchk(RTCCAL_FLAGS, 8'h01);
		host.wr(RTCCAL_CTRL_B, 8'h00);
		wave_seen(16);
		cmp("wave_hi", 8'h00, {7'h00, hi});
		results();
	end
endmodule
